// ==== tb/pci_target_burst_read_32_tb.sv ====
// Self-checking bench joining the initiator and target ends
`timescale 1ns/1ps
module pci_target_burst_read_32_tb;
  import ptb_pkg::*;

  // ************************************************************
  // Signals
  // ************************************************************
  localparam int CYCLE_LIMIT = 3000;
  localparam logic [31:0] WORD_BASE = 32'hA500_0000;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic start_i = 1'b0;
  logic [31:0] addr_i = 32'h0;
  logic [3:0] cmd_i = 4'h0;
  logic [3:0] byte_en_i = 4'h0;
  logic [7:0] beats_i = 8'h1;
  logic [31:0] rdata_o;
  logic rdata_valid_o, busy_o, abort_o;
  logic [31:0] local_address_out_o;
  logic [3:0] local_command_o, local_byte_en_o;
  logic [5:0] bar_hit_o;
  logic local_target_ready_n_i = 1'b1;
  logic local_beat_done_n_o;
  logic [31:0] local_rdata_i = WORD_BASE;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;

  ptb_if bus ();

  ptb_master i_ptb_master (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .bus(bus),
    .start_i(start_i), .addr_i(addr_i), .cmd_i(cmd_i), .byte_en_i(byte_en_i),
    .beats_i(beats_i), .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o),
    .busy_o(busy_o), .abort_o(abort_o));

  ptb_target i_ptb_target (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .bus(bus),
    .local_address_out_o(local_address_out_o), .local_command_o(local_command_o),
    .local_byte_en_o(local_byte_en_o), .bar_hit_o(bar_hit_o),
    .local_target_ready_n_i(local_target_ready_n_i),
    .local_beat_done_n_o(local_beat_done_n_o), .local_rdata_i(local_rdata_i));

  ptb_checker i_ptb_checker (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .framen(bus.framen), .irdyn(bus.irdyn), .devseln(bus.devseln), .trdyn(bus.trdyn),
    .m_framen_oe(bus.m_framen_oe), .m_cben_oe(bus.m_cben_oe), .m_ad_oe(bus.m_ad_oe),
    .t_devseln_oe(bus.t_devseln_oe), .t_trdyn_oe(bus.t_trdyn_oe), .t_ad_oe(bus.t_ad_oe));

  // ************************************************************
  // Clock, timeout and back end
  // ************************************************************
  initial begin
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  // Hang guard: counts as a failure, then reports
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == CYCLE_LIMIT) begin
      mismatches++;
      wrap_up();
    end
  end

  // Back end: ready from the clock after selection, next word after each strobe
  always @(posedge sys_clk_i) begin
    local_target_ready_n_i <= ~|bar_hit_o;
    if (local_beat_done_n_o === 1'b0) begin
      local_rdata_i <= local_rdata_i + 32'h1;
    end
  end

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Issue one read and follow it until the master goes idle
  task automatic run_read(input string name, input logic [31:0] a, input logic [3:0] c,
      input logic [3:0] b, input logic [7:0] n, input logic [5:0] hit);
    logic [31:0] first;
    logic [31:0] got;
    logic [31:0] want;
    logic [5:0] seen;
    logic aborted;
    int waited;
    int hit_at;
    int sel_at;
    int strobes;
    first = local_rdata_i;
    hit_at = 0;
    sel_at = 0;
    strobes = 0;
    got = 32'h0;
    want = (hit == 6'h00) ? 32'h0 : ((n == 8'h0) ? 32'h1 : {24'h0, n});
    seen = 6'h00;
    aborted = 1'b0;
    waited = 0;
    @(posedge sys_clk_i);
    start_i <= 1'b1;
    addr_i <= a;
    cmd_i <= c;
    byte_en_i <= b;
    beats_i <= n;
    @(posedge sys_clk_i);
    start_i <= 1'b0;
    do begin
      @(posedge sys_clk_i);
      #1;
      waited++;
      // First window hit and first claim, to measure the select lag
      if (seen == 6'h00 && bar_hit_o != 6'h00) hit_at = waited;
      if (sel_at == 0 && bus.devseln === 1'b0) sel_at = waited;
      if (local_beat_done_n_o === 1'b0) strobes++;
      seen = seen | bar_hit_o;
      if (abort_o === 1'b1) aborted = 1'b1;
      if (local_beat_done_n_o === 1'b0) check_word({28'h0, local_byte_en_o}, {28'h0, b});
      if (rdata_valid_o === 1'b1) begin
        check_word(rdata_o, first + got);
        got = got + 32'h1;
      end
    end while (busy_o !== 1'b0 && waited < 80);
    check_word({31'h0, busy_o}, 32'h0);
    check_word(got, want);
    check_word({26'h0, seen}, {26'h0, hit});
    check_word({31'h0, aborted}, {31'h0, hit == 6'h00});
    check_word(local_address_out_o, a);
    check_word({28'h0, local_command_o}, {28'h0, c});
    check_word(sel_at, (hit == 6'h00) ? 32'h0 : hit_at + 1);
    // One strobe per phase plus the spare word fetched in the final phase
    check_word(strobes, (hit == 6'h00) ? 32'h0 : want + 32'h1);
    check_word({26'h0, bar_hit_o}, 32'h0);
    $display("test %s done", name);
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (6) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    // Every burst command, both window edges, beat counts 1, 0, 3, 8
    run_read("read3", 32'h0000_0100, CMD_MEM_READ, 4'h0, 8'd3, 6'h01);
    run_read("mult8", 32'h2000_0040, CMD_MEM_READ_MULT, 4'h3, 8'd8, 6'h04);
    run_read("line1", 32'h5FFF_FFFC, CMD_MEM_READ_LINE, 4'hC, 8'd1, 6'h20);
    run_read("zero", 32'h1000_0000, CMD_MEM_READ, 4'h0, 8'd0, 6'h02);
    // Commands that must not be claimed, and a miss
    run_read("cfg", 32'h3000_0000, 4'hA, 4'h0, 8'd2, 6'h00);
    run_read("io", 32'h3000_0000, 4'h2, 4'h0, 8'd2, 6'h00);
    run_read("write", 32'h4000_0000, 4'h7, 4'h0, 8'd2, 6'h00);
    run_read("miss", 32'h6000_0000, CMD_MEM_READ, 4'h0, 8'd2, 6'h00);
    // Reset in mid-burst must drop every target drive and select
    @(posedge sys_clk_i);
    start_i <= 1'b1;
    addr_i <= 32'h0000_0200;
    cmd_i <= CMD_MEM_READ;
    beats_i <= 8'd8;
    @(posedge sys_clk_i);
    start_i <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    reset_n_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    check_word({26'h0, bar_hit_o}, 32'h0);
    check_word({31'h0, local_beat_done_n_o}, 32'h1);
    check_word({29'h0, bus.t_ad_oe, bus.t_trdyn_oe, bus.t_devseln_oe}, 32'h0);
    @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    $display("test reset done");
    run_read("after", 32'h4000_0010, CMD_MEM_READ_MULT, 4'h5, 8'd4, 6'h10);
    wrap_up();
  end
endmodule // pci_target_burst_read_32_tb

// ==== tb/ptb_checker.sv ====
// Concurrent checks on the shared PCI wires of the burst read path
`timescale 1ns/1ps
module ptb_checker
  import ptb_pkg::*;
(
  // Clock and reset
  input logic sys_clk_i,
  input logic reset_n_i,
  // Resolved wire levels
  input logic framen,
  input logic irdyn,
  input logic devseln,
  input logic trdyn,
  // Drive enables
  input logic m_framen_oe,
  input logic m_cben_oe,
  input logic m_ad_oe,
  input logic t_devseln_oe,
  input logic t_trdyn_oe,
  input logic t_ad_oe
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  // ************************************************************
  // Named steps of a burst
  // ************************************************************
  // Final data phase completing on the wire
  sequence last_phase;
    !trdyn && !irdyn && framen;
  endsequence
  // Turnaround: both ends drop their strobes and data
  sequence turnaround;
    devseln && trdyn && !t_ad_oe && irdyn && !m_framen_oe && !m_cben_oe;
  endsequence

  // ************************************************************
  // Assertions
  // ************************************************************
  // Slow select claims three clocks after the address phase
  a_slow_select_delay: assert property (
    $fell(devseln) |-> $past(framen, 3) == 1'b0 && $past(framen, 4) == 1'b1)
    else $error("devseln fell at the wrong distance from the address phase");
  a_trdyn_in_select: assert property (!trdyn |-> !devseln)
    else $error("trdyn low while devseln high");
  // Data phases only start after the claim has stood two cycles
  a_trdyn_after_select: assert property (
    $fell(trdyn) |-> $past(devseln, 1) == 1'b0 && $past(devseln, 2) == 1'b0)
    else $error("trdyn fell too soon after devseln");
  a_data_driven: assert property (!trdyn |-> t_ad_oe)
    else $error("trdyn low without target driving ad");
  a_no_contention: assert property (!(t_ad_oe && m_ad_oe))
    else $error("both ends drive ad");
  a_target_release: assert property (last_phase |=> turnaround)
    else $error("turnaround drives not dropped");
  a_idle_release: assert property (
    last_phase |=> ##1 !t_devseln_oe && !t_trdyn_oe)
    else $error("devseln or trdyn still driven in idle");
  a_master_release: assert property (
    last_phase |=> irdyn && !m_framen_oe && !m_cben_oe)
    else $error("master still drives frame or byte enables");
  a_frame_end_ready: assert property (
    ($rose(framen) && m_framen_oe) |-> !irdyn)
    else $error("framen raised without irdyn low");

  c_last_phase: cover property (last_phase);
endmodule // ptb_checker

// ==== verilog/ptb_if.sv ====
// Shared PCI wires between the initiator end and the target end
`timescale 1ns/1ps
interface ptb_if;
  import ptb_pkg::*;

  // Initiator drives
  logic m_framen_o, m_framen_oe;
  logic m_irdyn_o, m_irdyn_oe;
  logic [CBE_W-1:0] m_cben_o;
  logic m_cben_oe;
  logic [AD_W-1:0] m_ad_o;
  logic m_ad_oe;

  // Target drives
  logic t_devseln_o, t_devseln_oe;
  logic t_trdyn_o, t_trdyn_oe;
  logic [AD_W-1:0] t_ad_o;
  logic t_ad_oe;

  // Resolved wire levels, undriven lines float high on the pull-ups
  logic framen, irdyn, devseln, trdyn;
  logic [CBE_W-1:0] cben;
  logic [AD_W-1:0] ad;

  assign framen = m_framen_oe ? m_framen_o : 1'b1;
  assign irdyn = m_irdyn_oe ? m_irdyn_o : 1'b1;
  assign cben = m_cben_oe ? m_cben_o : 4'hF;
  assign devseln = t_devseln_oe ? t_devseln_o : 1'b1;
  assign trdyn = t_trdyn_oe ? t_trdyn_o : 1'b1;
  assign ad = t_ad_oe ? t_ad_o : (m_ad_oe ? m_ad_o : AD_PULLUP);

  modport initiator (
    output m_framen_o, m_framen_oe, m_irdyn_o, m_irdyn_oe,
    output m_cben_o, m_cben_oe, m_ad_o, m_ad_oe,
    input devseln, trdyn, ad
  );

  modport target (
    output t_devseln_o, t_devseln_oe, t_trdyn_o, t_trdyn_oe, t_ad_o, t_ad_oe,
    input framen, irdyn, cben, ad
  );
endinterface

// ==== verilog/ptb_master.sv ====
// PCI initiator end issuing memory burst reads
`timescale 1ns/1ps
module ptb_master
  import ptb_pkg::*;
#(
  parameter int BEAT_W = 8
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // PCI side
  ptb_if.initiator bus,
  // User command port
  input wire logic start_i,
  input wire logic [AD_W-1:0] addr_i,
  input wire logic [CBE_W-1:0] cmd_i,
  input wire logic [CBE_W-1:0] byte_en_i,
  input wire logic [BEAT_W-1:0] beats_i,
  // User answer port
  output logic [AD_W-1:0] rdata_o,
  output logic rdata_valid_o,
  output logic busy_o,
  output logic abort_o
);

  if (BEAT_W < 1) begin : g_chk
    $error("ptb_master: BEAT_W must be at least 1");
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_ADDR = 2'b01,
    M_DATA = 2'b10,
    M_TURN = 2'b11
  } ptb_mstate_t;

  ptb_mstate_t state_q;
  logic [BEAT_W-1:0] left_q;
  logic [3:0] wait_q;
  logic done_w, no_claim_w;

  // A phase completes when both ready strobes are low
  assign done_w = (state_q == M_DATA) && !bus.m_irdyn_o && !bus.trdyn;
  assign no_claim_w = (state_q == M_DATA) && bus.devseln && (wait_q == MASTER_ABORT_CYCLES);

  // State and remaining beats; zero beats is served as one
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= M_IDLE;
      left_q <= '0;
      wait_q <= 4'h0;
    end else begin
      unique case (state_q)
        M_IDLE: begin
          if (start_i) begin
            state_q <= M_ADDR;
            left_q <= (beats_i == '0) ? BEAT_W'(1) : beats_i;
          end
          wait_q <= 4'h0;
        end
        M_ADDR: state_q <= M_DATA;
        M_DATA: begin
          wait_q <= wait_q + 4'h1;
          if (done_w) begin
            left_q <= left_q - BEAT_W'(1);
          end
          if ((done_w && left_q == BEAT_W'(1)) || no_claim_w) begin
            state_q <= M_TURN;
          end
        end
        M_TURN: state_q <= M_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Pin drive
  // ************************************************************
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bus.m_framen_o <= 1'b1;
      bus.m_framen_oe <= 1'b0;
      bus.m_irdyn_o <= 1'b1;
      bus.m_irdyn_oe <= 1'b0;
      bus.m_cben_o <= CBE_RESET;
      bus.m_cben_oe <= 1'b0;
      bus.m_ad_o <= AD_RESET;
      bus.m_ad_oe <= 1'b0;
    end else begin
      unique case (state_q)
        M_IDLE: begin
          bus.m_irdyn_oe <= 1'b0;
          if (start_i) begin
            // Address phase: frame, address and command
            bus.m_framen_o <= 1'b0;
            bus.m_framen_oe <= 1'b1;
            bus.m_ad_o <= addr_i;
            bus.m_ad_oe <= 1'b1;
            bus.m_cben_o <= cmd_i;
            bus.m_cben_oe <= 1'b1;
          end
        end
        M_ADDR: begin
          bus.m_ad_oe <= 1'b0;
          bus.m_cben_o <= byte_en_i;
          bus.m_irdyn_o <= 1'b0;
          bus.m_irdyn_oe <= 1'b1;
          bus.m_framen_o <= (left_q == BEAT_W'(1));
        end
        M_DATA: begin
          if ((done_w && left_q == BEAT_W'(1)) || no_claim_w) begin
            // Turnaround: let go of frame and byte enables, raise irdyn
            bus.m_framen_o <= 1'b1;
            bus.m_framen_oe <= 1'b0;
            bus.m_cben_oe <= 1'b0;
            bus.m_irdyn_o <= 1'b1;
          end else if (done_w && left_q == BEAT_W'(2)) begin
            bus.m_framen_o <= 1'b1;
          end
        end
        M_TURN: bus.m_irdyn_oe <= 1'b0;
      endcase
    end
  end

  // ************************************************************
  // User answers
  // ************************************************************
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= AD_RESET;
      rdata_valid_o <= 1'b0;
      busy_o <= 1'b0;
      abort_o <= 1'b0;
    end else begin
      rdata_valid_o <= done_w;
      if (done_w) begin
        rdata_o <= bus.ad;
      end
      busy_o <= (state_q != M_IDLE) || start_i;
      abort_o <= no_claim_w; // Nobody claimed the cycle
    end
  end

endmodule // ptb_master

// ==== verilog/ptb_pkg.sv ====
// Shared constants for the 32-bit target burst read path
package ptb_pkg;

  // ************************************************************
  // Bus widths and window count
  // ************************************************************
  localparam int AD_W = 32;
  localparam int CBE_W = 4;
  localparam int BAR_COUNT = 6;

  // ************************************************************
  // Bus commands that may burst (memory reads only)
  // ************************************************************
  localparam logic [3:0] CMD_MEM_READ = 4'h6;
  localparam logic [3:0] CMD_MEM_READ_MULT = 4'hC;
  localparam logic [3:0] CMD_MEM_READ_LINE = 4'hE;

  // ************************************************************
  // Device-select speed settings
  // ************************************************************
  localparam logic [1:0] DEVSEL_FAST = 2'h0;
  localparam logic [1:0] DEVSEL_SLOW = 2'h2;

  // ************************************************************
  // Reset values and timing counts
  // ************************************************************
  localparam logic [31:0] AD_RESET = 32'h0000_0000;
  localparam logic [31:0] AD_PULLUP = 32'hFFFF_FFFF;
  localparam logic [3:0] CBE_RESET = 4'h0;
  localparam logic [5:0] BAR_HIT_NONE = 6'h00;
  localparam logic [3:0] MASTER_ABORT_CYCLES = 4'h5;

endpackage

// ==== verilog/ptb_target.sv ====
// PCI target end: 32-bit burst read bridged to a local back end
`timescale 1ns/1ps
module ptb_target
  import ptb_pkg::*;
#(
  parameter logic [1:0] DEVICE_SELECT_SPEED_SETTING = DEVSEL_SLOW,
  parameter logic [BAR_COUNT*AD_W-1:0] BAR_BASES = {
    32'h5000_0000, 32'h4000_0000, 32'h3000_0000,
    32'h2000_0000, 32'h1000_0000, 32'h0000_0000
  },
  parameter logic [BAR_COUNT*AD_W-1:0] BAR_MASKS = {BAR_COUNT{32'hF000_0000}}
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // PCI side
  ptb_if.target bus,
  // Local back-end side
  output logic [AD_W-1:0] local_address_out_o,
  output logic [CBE_W-1:0] local_command_o,
  output logic [CBE_W-1:0] local_byte_en_o,
  output logic [BAR_COUNT-1:0] bar_hit_o,
  input wire logic local_target_ready_n_i,
  output logic local_beat_done_n_o,
  input wire logic [AD_W-1:0] local_rdata_i
);

  if (DEVICE_SELECT_SPEED_SETTING != DEVSEL_FAST &&
      DEVICE_SELECT_SPEED_SETTING != DEVSEL_SLOW) begin : g_chk
    $error("ptb_target: only fast or slow device select is served");
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  // Window match for each base/mask pair
  function automatic logic [BAR_COUNT-1:0] window_match(input logic [AD_W-1:0] a);
    logic [BAR_COUNT-1:0] m;
    m = '0;
    for (int i = 0; i < BAR_COUNT; i++) begin
      m[i] = ((a & BAR_MASKS[i*AD_W +: AD_W]) == (BAR_BASES[i*AD_W +: AD_W] &
              BAR_MASKS[i*AD_W +: AD_W]));
    end
    return m;
  endfunction

  // Only memory reads are served; config and I/O never burst
  function automatic logic is_mem_read(input logic [CBE_W-1:0] c);
    return (c == CMD_MEM_READ) || (c == CMD_MEM_READ_MULT) ||
           (c == CMD_MEM_READ_LINE);
  endfunction

  // First window wins when windows overlap
  function automatic logic [BAR_COUNT-1:0] first_bit(input logic [BAR_COUNT-1:0] v);
    return v & (~v + BAR_COUNT'(1));
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DECODE = 3'b001,
    ST_HIT = 3'b010,
    ST_CLAIM = 3'b011,
    ST_TURN = 3'b100
  } ptb_tstate_t;

  ptb_tstate_t state_q;
  logic framen_q;
  logic ready_seen_q;
  logic started_q;
  logic [BAR_COUNT-1:0] hit_w;
  logic addr_phase_w, claim_w, last_done_w, ready_w, trdyn_d, beat_d;

  // Falling frame seen from idle marks the address phase
  assign addr_phase_w = (state_q == ST_IDLE) && !bus.framen && framen_q;
  assign claim_w = (state_q == ST_CLAIM);
  assign ready_w = !local_target_ready_n_i;
  // Final phase completes: frame high, both ready strobes low
  assign last_done_w = claim_w && bus.framen && !bus.irdyn && !bus.t_trdyn_o;
  assign hit_w = first_bit(window_match(local_address_out_o)) &
                 {BAR_COUNT{is_mem_read(local_command_o)}};
  // Ready this cycle and last cycle keeps trdyn low next cycle
  assign trdyn_d = !(claim_w && !last_done_w && ready_w && ready_seen_q);
  // Strobe: first on ready alone, then on ready with irdyn
  assign beat_d = claim_w && !last_done_w && ready_w &&
                  (!started_q || !bus.irdyn);

  // Previous frame level, for start detection
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      framen_q <= 1'b1;
    end else begin
      framen_q <= bus.framen;
    end
  end

  // Transaction sequencer
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: if (addr_phase_w) state_q <= ST_DECODE;
        ST_DECODE: begin
          if (hit_w == BAR_HIT_NONE) begin
            state_q <= ST_IDLE;
          end else if (DEVICE_SELECT_SPEED_SETTING == DEVSEL_FAST) begin
            state_q <= ST_CLAIM;
          end else begin
            state_q <= ST_HIT;
          end
        end
        ST_HIT: state_q <= ST_CLAIM;
        ST_CLAIM: if (last_done_w) state_q <= ST_TURN;
        ST_TURN: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Local side: address, command, window hits
  // ************************************************************
  // Address and command captured in the address phase, byte enables every clock, shown from the next clock
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      local_address_out_o <= AD_RESET;
      local_command_o <= CBE_RESET;
      local_byte_en_o <= CBE_RESET;
    end else begin
      if (addr_phase_w) begin
        local_address_out_o <= bus.ad;
        local_command_o <= bus.cben;
      end
      local_byte_en_o <= bus.cben;
    end
  end

  // Hit bit acts as chip select until turnaround
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bar_hit_o <= BAR_HIT_NONE;
    end else if (state_q == ST_DECODE) begin
      bar_hit_o <= hit_w;
    end else if (last_done_w || state_q == ST_IDLE) begin
      bar_hit_o <= BAR_HIT_NONE;
    end
  end

  // ************************************************************
  // Local side: ready history and beat strobe
  // ************************************************************
  // The back end may raise ready one cycle ahead of its data
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ready_seen_q <= 1'b0;
      started_q <= 1'b0;
    end else begin
      ready_seen_q <= claim_w && ready_w;
      if (!claim_w) begin
        started_q <= 1'b0;
      end else if (beat_d) begin
        started_q <= 1'b1;
      end
    end
  end

  // Strobe drops in turnaround since last_done_w blocks it
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      local_beat_done_n_o <= 1'b1;
    end else begin
      local_beat_done_n_o <= !beat_d;
    end
  end

  // ************************************************************
  // PCI side: devseln, trdyn, ad
  // ************************************************************
  // Slow setting lags the hit by one clock, fast setting does not
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bus.t_devseln_o <= 1'b1;
      bus.t_devseln_oe <= 1'b0;
    end else begin
      if ((state_q == ST_HIT) ||
          (state_q == ST_DECODE && hit_w != BAR_HIT_NONE &&
           DEVICE_SELECT_SPEED_SETTING == DEVSEL_FAST)) begin
        bus.t_devseln_o <= 1'b0;
        bus.t_devseln_oe <= 1'b1;
      end else if (last_done_w) begin
        bus.t_devseln_o <= 1'b1;
      end else if (state_q == ST_TURN) begin
        bus.t_devseln_oe <= 1'b0;
      end
    end
  end

  // trdyn driven high through turnaround, then released
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bus.t_trdyn_o <= 1'b1;
      bus.t_trdyn_oe <= 1'b0;
    end else begin
      bus.t_trdyn_o <= trdyn_d;
      if (claim_w) begin
        bus.t_trdyn_oe <= 1'b1;
      end else if (state_q == ST_TURN) begin
        bus.t_trdyn_oe <= 1'b0;
      end
    end
  end

  // A word is taken on each strobe cycle; the strobe lags irdyn by a cycle, so the first master wait cycle still loads a new word
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bus.t_ad_o <= AD_RESET;
      bus.t_ad_oe <= 1'b0;
    end else begin
      if (claim_w && !local_beat_done_n_o) begin
        bus.t_ad_o <= local_rdata_i;
      end
      if (!trdyn_d) begin
        bus.t_ad_oe <= 1'b1;
      end else if (last_done_w || !claim_w) begin
        bus.t_ad_oe <= 1'b0;
      end
    end
  end

endmodule // ptb_target
